/* hw/ppc_pkg.sv */
// Purpose: Shared constants and types of the PHY port control/status bank
// Assumes: Avalon-MM byte addressing, one 32-bit word per register
// Notes:   Register indices are word indices; byte address is index * 4
package ppc_pkg;

  // ---------------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------------
  localparam int ADDR_W  = 9;            // Byte address width
  localparam int IDX_W   = 7;            // Word index width
  localparam int DATA_W  = 32;           // Bus data width
  localparam int BE_W    = 4;            // Byte enable width
  localparam int REG_W   = 8;            // Width of each PHY register
  localparam int NPORT   = 2;            // Number of PHY ports

  // ---------------------------------------------------------------------
  // Register indices (byte address = index * 4)
  // ---------------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_P1_CTRL  = 7'h1d; // Port 1 control low
  localparam logic [IDX_W-1:0] IDX_P1_STAT  = 7'h1e; // Port 1 status first
  localparam logic [IDX_W-1:0] IDX_P2_CTRL  = 7'h2d; // Port 2 control low
  localparam logic [IDX_W-1:0] IDX_P2_STAT  = 7'h2e; // Port 2 status first
  localparam logic [IDX_W-1:0] IDX_P3_RSVD  = 7'h3e; // Port 3 slot, reserved
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 7'h50; // Event status, W1C
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 7'h51; // Event mask

  // ---------------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------------
  localparam int CTL_W     = 3;          // Implemented control bits
  localparam int CTL_LOOP  = 0;          // Cross-port loopback
  localparam int CTL_FORCE = 1;          // Forced wiring select
  localparam int CTL_XOFF  = 2;          // Auto crossover detect disable
  localparam logic [CTL_W-1:0] CTL_RST = 3'h0; // Control reset value

  // ---------------------------------------------------------------------
  // Event status fields, two bits per port
  // ---------------------------------------------------------------------
  localparam int IRQ_PP    = 2;          // Event bits per port
  localparam int IRQ_LINK  = 0;          // Link good changed
  localparam int IRQ_AN    = 1;          // Negotiation completed
  localparam int IRQ_W     = 4;          // Total event bits
  localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0; // Status and mask reset

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  // Live PHY results, packed in status register bit order 7..0
  typedef struct packed {
    logic xover_active;                  // Crossover wiring in use
    logic negotiation_complete_flag;     // Auto-negotiation done
    logic link_good;                     // Link is up
    logic partner_pause;                 // Partner pause capable
    logic partner_100fd;                 // Partner 100M full duplex
    logic partner_100hd;                 // Partner 100M half duplex
    logic partner_10fd;                  // Partner 10M full duplex
    logic partner_10hd;                  // Partner 10M half duplex
  } ppc_phy_stat_t;

  // Controls handed to one PHY
  typedef struct packed {
    logic auto_xover_en;                 // Automatic wiring detection on
    logic tx_on_receive_pair;            // Forced straight wiring
    logic loopback;                      // Cross-port PMD/PMA loopback
  } ppc_phy_ctrl_t;

  // Bus answer state
  typedef enum logic {
    PPC_IDLE = 1'b0,                     // Waiting for a request
    PPC_ACK  = 1'b1                      // Answering, waitrequest low
  } ppc_bus_st_t;

endpackage

/* hw/ppc_regs.sv */
// Purpose: PHY port control and first status registers, two PHY ports
// Assumes: Avalon-MM slave, one wait state per access, clk_sys 50 MHz
// Notes:   Status registers mirror live PHY results; enabled events raise irq
`timescale 1ns/10ps

module ppc_regs (
  input  wire logic                               clk_sys,
  input  wire logic                               arst_n,
  input  wire logic [ppc_pkg::ADDR_W-1:0]         avs_address,
  input  wire logic                               avs_read,
  input  wire logic                               avs_write,
  input  wire logic [ppc_pkg::DATA_W-1:0]         avs_writedata,
  input  wire logic [ppc_pkg::BE_W-1:0]           avs_byteenable,
  output logic      [ppc_pkg::DATA_W-1:0]         avs_readdata,
  output logic                                    avs_waitrequest,
  input  wire logic                               strap_port2_crossover_detect_off,
  input  wire logic                               strap_port2_forced_wiring,
  input  wire ppc_pkg::ppc_phy_stat_t [ppc_pkg::NPORT-1:0] phy_stat,
  output ppc_pkg::ppc_phy_ctrl_t      [ppc_pkg::NPORT-1:0] phy_ctrl,
  output logic                                    irq
);
  import ppc_pkg::*;

  // ---------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------
  ppc_bus_st_t             bus_st;        // Answer state
  logic [IDX_W-1:0]        idx;           // Word index of request
  logic                    req;           // Any request pending
  logic                    wr_take;       // Write takes effect now
  logic                    rd_load;       // Read data loaded now
  logic                    wr_lo;         // Write touches low byte
  logic                    strap_taken;   // Straps already captured
  logic [CTL_W-1:0]        ctrl [NPORT];  // Control registers
  ppc_phy_stat_t           stat_prev [NPORT]; // Last seen PHY status
  logic [IRQ_W-1:0]        irq_stat;      // Sticky event bits
  logic [IRQ_W-1:0]        irq_mask;      // Event enables
  logic [IRQ_W-1:0]        irq_evt;       // Events this cycle
  logic [DATA_W-1:0]       next_rdata;    // Read mux result

  // ---------------------------------------------------------------------
  // Request decode
  // ---------------------------------------------------------------------
  assign idx     = avs_address[ADDR_W-1:2];
  assign req     = avs_read | avs_write;
  // Write lands only on the edge where waitrequest is low
  assign wr_take = avs_write & (bus_st == PPC_ACK);
  assign rd_load = avs_read & (bus_st == PPC_IDLE);
  // Every register lives in byte lane 0
  assign wr_lo   = wr_take & avs_byteenable[0];

  // Waitrequest low in the answer cycle and while no request is pending
  assign avs_waitrequest = req & (bus_st != PPC_ACK);

  // Answer state: one wait cycle, then one answer cycle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      bus_st <= PPC_IDLE;
    end else begin
      case (bus_st)
        PPC_IDLE: begin
          // Request seen, answer next cycle
          if (req) begin
            bus_st <= PPC_ACK;
          end
        end
        PPC_ACK: begin
          // Request completes at this edge
          bus_st <= PPC_IDLE;
        end
        default: begin
          bus_st <= PPC_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Strap capture
  // ---------------------------------------------------------------------
  // Straps are sampled on the first edge after reset release
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      strap_taken <= 1'b0;
    end else begin
      strap_taken <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------
  // Per-port control registers and outputs
  // ---------------------------------------------------------------------
  for (genvar g = 0; g < NPORT; g++) begin : g_port
    localparam logic [IDX_W-1:0] CIDX = (g == 0) ? IDX_P1_CTRL : IDX_P2_CTRL;
    logic [CTL_W-1:0] next_ctrl;           // Control value after edge

    // Next control value: strap, then bus write, else hold
    always_comb begin
      next_ctrl = ctrl[g];
      if (!strap_taken) begin
        // Port 1 stays at reset value, port 2 takes its straps
        next_ctrl = CTL_RST;
        if (g == 1) begin
          next_ctrl[CTL_XOFF]  = strap_port2_crossover_detect_off;
          next_ctrl[CTL_FORCE] = strap_port2_forced_wiring;
        end
      end else if (wr_lo && idx == CIDX) begin
        // Software write of the implemented low bits
        next_ctrl = avs_writedata[CTL_W-1:0];
      end
    end

    // Control register and its decoded PHY outputs
    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        ctrl[g]     <= CTL_RST;
        phy_ctrl[g] <= '{auto_xover_en: 1'b1,
                         tx_on_receive_pair: 1'b0,
                         loopback: 1'b0};
      end else begin
        ctrl[g] <= next_ctrl;
        // Clear disable bit keeps automatic detection
        phy_ctrl[g].auto_xover_en <= ~next_ctrl[CTL_XOFF];
        // Forced wiring only matters with detection off
        phy_ctrl[g].tx_on_receive_pair <=
          next_ctrl[CTL_XOFF] & next_ctrl[CTL_FORCE];
        // Loopback of the opposite port through this PHY
        phy_ctrl[g].loopback <= next_ctrl[CTL_LOOP];
      end
    end

    // Previous status, for change detection
    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        stat_prev[g] <= '0;
      end else begin
        stat_prev[g] <= phy_stat[g];
      end
    end

    // Link change in either direction, negotiation completion
    assign irq_evt[g*IRQ_PP+IRQ_LINK] =
      phy_stat[g].link_good ^ stat_prev[g].link_good;
    assign irq_evt[g*IRQ_PP+IRQ_AN] =
      phy_stat[g].negotiation_complete_flag &
      ~stat_prev[g].negotiation_complete_flag;

    // Disable bit written clear turns detection back on
    xover_on_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      wr_lo && idx == CIDX && !avs_writedata[CTL_XOFF]
      |=> phy_ctrl[g].auto_xover_en)
      else $error("crossover detection not enabled");

    // Disable bit written set turns detection off
    xover_off_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      wr_lo && idx == CIDX && avs_writedata[CTL_XOFF]
      |=> !phy_ctrl[g].auto_xover_en)
      else $error("crossover detection not disabled");

    // Forced wiring follows the forced bit while detection is off
    wiring_sel_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !phy_ctrl[g].auto_xover_en
      |-> phy_ctrl[g].tx_on_receive_pair == ctrl[g][CTL_FORCE])
      else $error("forced wiring does not follow control");

    // Loopback written clear leaves normal operation
    loop_clr_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      wr_lo && idx == CIDX && !avs_writedata[CTL_LOOP]
      |=> !phy_ctrl[g].loopback)
      else $error("loopback still active after clear");

    // Write to a status word changes no control
    stat_ro_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      strap_taken && wr_take && (idx == IDX_P1_STAT || idx == IDX_P2_STAT)
      |=> phy_ctrl[g] == $past(phy_ctrl[g]))
      else $error("status write disturbed control");

    // Control holds unless its own word is written
    ctl_hold_a: assert property (@(posedge clk_sys)
      disable iff (!arst_n)
      strap_taken && !(wr_lo && idx == CIDX)
      |=> ctrl[g] == $past(ctrl[g]))
      else $error("control changed without a write");
  end

  // Port 1 loopback bit drives the port 1 PHY loop
  loop_p1_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wr_lo && idx == IDX_P1_CTRL && avs_writedata[CTL_LOOP]
    |=> phy_ctrl[0].loopback && !$past(phy_ctrl[1].loopback) ==
        !phy_ctrl[1].loopback)
    else $error("port 1 loopback not set");

  // Port 2 loopback bit drives the port 2 PHY loop
  loop_p2_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wr_lo && idx == IDX_P2_CTRL && avs_writedata[CTL_LOOP]
    |=> phy_ctrl[1].loopback)
    else $error("port 2 loopback not set");

  // Straps land in port 2, port 1 keeps reset values
  strap_load_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(strap_taken)
    |-> ctrl[1][CTL_FORCE] == $past(strap_port2_forced_wiring) &&
        ctrl[0] == CTL_RST)
    else $error("strap values not captured");

  // Port 2 disable bit from strap, loopback from reset
  strap_xoff_a: assert property (@(posedge clk_sys)
    disable iff (!arst_n)
    $rose(strap_taken)
    |-> ctrl[1][CTL_XOFF] == $past(strap_port2_crossover_detect_off) &&
        ctrl[1][CTL_LOOP] == 1'b0)
    else $error("strap disable bit not captured");

  // ---------------------------------------------------------------------
  // Event status and mask
  // ---------------------------------------------------------------------
  // Sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat <= IRQ_RST;
    end else if (wr_lo && idx == IDX_IRQ_STAT) begin
      irq_stat <= (irq_stat & ~avs_writedata[IRQ_W-1:0]) | irq_evt;
    end else begin
      irq_stat <= irq_stat | irq_evt;
    end
  end

  // Mask register, one enable per event bit
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_mask <= IRQ_RST;
    end else if (wr_lo && idx == IDX_IRQ_MASK) begin
      irq_mask <= avs_writedata[IRQ_W-1:0];
    end
  end

  // Level interrupt while any enabled event is pending
  assign irq = |(irq_stat & irq_mask);

  // Event raised in a clear cycle stays pending
  evt_keep_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    irq_evt != '0 |=> (irq_stat & $past(irq_evt)) == $past(irq_evt))
    else $error("event lost");

  // Writing ones clears pending bits when no event collides
  clr_w1c_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wr_lo && idx == IDX_IRQ_STAT && irq_evt == '0
    |=> (irq_stat & $past(avs_writedata[IRQ_W-1:0])) == '0)
    else $error("pending event not cleared");

  // Mask takes the written enables
  mask_wr_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wr_lo && idx == IDX_IRQ_MASK
    |=> irq_mask == $past(avs_writedata[IRQ_W-1:0]))
    else $error("mask not written");

  // ---------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------
  // Read mux; status words are live, unmapped words read zero
  always_comb begin
    next_rdata = '0;
    case (idx)
      IDX_P1_CTRL: begin
        next_rdata[CTL_W-1:0] = ctrl[0];
      end
      IDX_P1_STAT: begin
        next_rdata[REG_W-1:0] = phy_stat[0];
      end
      IDX_P2_CTRL: begin
        next_rdata[CTL_W-1:0] = ctrl[1];
      end
      IDX_P2_STAT: begin
        next_rdata[REG_W-1:0] = phy_stat[1];
      end
      IDX_IRQ_STAT: begin
        next_rdata[IRQ_W-1:0] = irq_stat;
      end
      IDX_IRQ_MASK: begin
        next_rdata[IRQ_W-1:0] = irq_mask;
      end
      default: begin
        // Reserved port 3 slot and unmapped words read zero
        next_rdata = '0;
      end
    endcase
  end

  // Read data captured in the wait cycle, held until next read
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= '0;
    end else if (rd_load) begin
      avs_readdata <= next_rdata;
    end
  end

  // Every request is answered after exactly one wait cycle
  bus_wait_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    req && bus_st == PPC_IDLE |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("answer not after one wait cycle");

  // Port 1 status word carries live crossover, link and partner bits
  stat_p1_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    avs_read && !avs_waitrequest && idx == IDX_P1_STAT
    |-> avs_readdata == {24'h0, $past(phy_stat[0])})
    else $error("port 1 status read wrong");

  // Port 2 status word carries pause and speed capability bits
  stat_p2_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    avs_read && !avs_waitrequest && idx == IDX_P2_STAT
    |-> avs_readdata[REG_W-1:0] == $past(phy_stat[1]) &&
        avs_readdata[DATA_W-1:REG_W] == 24'h0)
    else $error("port 2 status read wrong");

  // Reserved port 3 slot answers zero
  rsvd_zero_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    avs_read && !avs_waitrequest && idx == IDX_P3_RSVD
    |-> avs_readdata == 32'h0)
    else $error("reserved slot not zero");

  // Read data stands until the next read is loaded
  rdata_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !rd_load |=> $stable(avs_readdata))
    else $error("read data changed without a read");

  // Writes to the reserved slot touch no register
  rsvd_wr_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wr_take && idx == IDX_P3_RSVD
    |=> irq_mask == $past(irq_mask) && ctrl[0] == $past(ctrl[0]) &&
        ctrl[1] == $past(ctrl[1]))
    else $error("reserved write changed a register");

endmodule // ppc_regs

/* verif/ppc_link_partner.sv */
// Purpose: Cable and link partner model driving live PHY results
// Assumes: Bench picks partner abilities and cable wiring per port
// Notes:   Wiring result follows controls once detection is off
`timescale 1ns/10ps

module ppc_link_partner (
  input  wire logic                                        clk_sys,
  input  wire logic                                        arst_n,
  input  wire ppc_pkg::ppc_phy_ctrl_t [ppc_pkg::NPORT-1:0] phy_ctrl,
  input  wire ppc_pkg::ppc_phy_stat_t [ppc_pkg::NPORT-1:0] want,
  output ppc_pkg::ppc_phy_stat_t      [ppc_pkg::NPORT-1:0] phy_stat
);
  import ppc_pkg::*;

  // -------------------------------------------------------------------
  // Results land one cycle after cable or controls change
  // -------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      phy_stat <= '0;                      // Link down in reset
    end else begin
      for (int i = 0; i < NPORT; i++) begin
        phy_stat[i] <= want[i];            // Cable detect result
        if (!phy_ctrl[i].auto_xover_en) begin
          phy_stat[i].xover_active <= !phy_ctrl[i].tx_on_receive_pair;
        end
      end
    end
  end
endmodule // ppc_link_partner

/* verif/ppc_regs_bench.sv */
// Purpose: Self-checking bench of the PHY port register bank
// Assumes: Master waits on waitrequest; no fixed answer latency assumed
// Notes:   Model of registers and events is compared at every read
`timescale 1ns/10ps

module ppc_regs_bench;
  import ppc_pkg::*;

  // -------------------------------------------------------------------
  // Signals and model state
  // -------------------------------------------------------------------
  logic                      clk_sys, arst_n, avs_read, avs_write, irq;
  logic                      avs_waitrequest, s_off, s_frc;
  logic [ADDR_W-1:0]         avs_address;
  logic [DATA_W-1:0]         avs_writedata, avs_readdata, q;
  logic [BE_W-1:0]           avs_byteenable;
  ppc_phy_stat_t [NPORT-1:0] phy_stat, want;   // Live results, cable
  ppc_phy_ctrl_t [NPORT-1:0] phy_ctrl;
  int                        failures, n_checks;
  logic [CTL_W-1:0]          m_ctl [NPORT];    // Model control regs
  logic [IRQ_W-1:0]          m_irq, m_mask;    // Model events, mask
  logic [ADDR_W-1:0]         amap [8] = '{{IDX_P1_CTRL, 2'h0},
    {IDX_P1_STAT, 2'h0}, {IDX_P2_CTRL, 2'h0}, {IDX_P2_STAT, 2'h0},
    {IDX_P3_RSVD, 2'h0}, {IDX_IRQ_STAT, 2'h0}, {IDX_IRQ_MASK, 2'h0},
    9'h100};                                    // Last one unmapped

  ppc_regs u_ppc_regs (.clk_sys(clk_sys), .arst_n(arst_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .strap_port2_crossover_detect_off(s_off),
    .strap_port2_forced_wiring(s_frc), .phy_stat(phy_stat),
    .phy_ctrl(phy_ctrl), .irq(irq));
  ppc_link_partner u_ppc_link_partner (.clk_sys(clk_sys),
    .arst_n(arst_n), .phy_ctrl(phy_ctrl), .want(want),
    .phy_stat(phy_stat));

  // Clock, 20 ns period
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // -------------------------------------------------------------------
  // Model functions and checking
  // -------------------------------------------------------------------
  function automatic logic [DATA_W-1:0] m_stat(int p);
    logic [DATA_W-1:0] v;
    v = DATA_W'(want[p]);
    if (m_ctl[p][CTL_XOFF]) begin
      v[7] = !m_ctl[p][CTL_FORCE];         // Forced wiring shows here
    end
    return v;
  endfunction

  function automatic logic [DATA_W-1:0] m_read(logic [ADDR_W-1:0] a);
    case (a[ADDR_W-1:2])
      IDX_P1_CTRL:  return DATA_W'(m_ctl[0]);
      IDX_P2_CTRL:  return DATA_W'(m_ctl[1]);
      IDX_P1_STAT:  return m_stat(0);
      IDX_P2_STAT:  return m_stat(1);
      IDX_IRQ_STAT: return DATA_W'(m_irq);
      IDX_IRQ_MASK: return DATA_W'(m_mask);
      default:      return '0;             // Reserved and unmapped
    endcase
  endfunction

  function automatic logic [DATA_W-1:0] m_phy(int p);
    return DATA_W'({!m_ctl[p][CTL_XOFF],
      m_ctl[p][CTL_XOFF] & m_ctl[p][CTL_FORCE], m_ctl[p][CTL_LOOP]});
  endfunction

  task automatic chk(string nm, logic [DATA_W-1:0] s, logic [DATA_W-1:0] e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // -------------------------------------------------------------------
  // Bus master and stimulus tasks
  // -------------------------------------------------------------------
  task automatic bus(bit wr, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d,
                     logic [BE_W-1:0] be);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    // Waitrequest sampled at rising edges; data taken where it is low
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      chk("waitrequest", DATA_W'(avs_waitrequest), '0);
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (wr && be[0]) begin
      case (a[ADDR_W-1:2])
        IDX_P1_CTRL:  m_ctl[0] = d[CTL_W-1:0];
        IDX_P2_CTRL:  m_ctl[1] = d[CTL_W-1:0];
        IDX_IRQ_STAT: m_irq &= ~d[IRQ_W-1:0];
        IDX_IRQ_MASK: m_mask = d[IRQ_W-1:0];
        default: ;                         // Status writes dropped
      endcase
    end
  endtask

  task automatic check_all();
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, amap[i], '0, 4'hf);
      chk("readdata", q, m_read(amap[i]));
    end
    @(negedge clk_sys);
    chk("phy_ctrl0", DATA_W'(phy_ctrl[0]), m_phy(0));
    chk("phy_ctrl1", DATA_W'(phy_ctrl[1]), m_phy(1));
    chk("irq", DATA_W'(irq), DATA_W'((m_irq & m_mask) != 0));
  endtask

  // New partner state; model records link and negotiation events
  task automatic set_lp(int p, ppc_phy_stat_t v);
    @(posedge clk_sys);
    if (want[p].link_good != v.link_good) begin
      m_irq[p*IRQ_PP+IRQ_LINK] = 1'b1;
    end
    if (!want[p].negotiation_complete_flag &&
        v.negotiation_complete_flag) begin
      m_irq[p*IRQ_PP+IRQ_AN] = 1'b1;
    end
    want[p] <= v;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic do_reset();
    arst_n <= 1'b0;
    s_off <= 1'($urandom);
    s_frc <= 1'($urandom);
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    m_ctl[0] = CTL_RST;
    m_ctl[1] = {s_off, s_frc, 1'b0};
    m_irq = IRQ_RST;
    m_mask = IRQ_RST;
    @(posedge clk_sys);
  endtask

  // Watchdog
  initial begin
    #1000000;
    failures++;
    close_out();
  end

  // -------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------
  initial begin
    {arst_n, avs_read, avs_write, s_off, s_frc} = '0;
    {avs_address, avs_writedata, avs_byteenable} = '0;
    {failures, n_checks} = '0;
    want = '0;
    void'($urandom(35605));
    do_reset();
    check_all();
    for (int c = 0; c < 8; c++) begin       // Every control code
      bus(1'b1, amap[0], 32'(c), 4'h1);
      bus(1'b1, amap[2], 32'(7 - c), 4'h1);
      set_lp(c % 2, ppc_phy_stat_t'(8'(c * 37)));
      check_all();
    end
    bus(1'b1, amap[6], 32'hf, 4'h1);        // Unmask all events
    set_lp(0, 8'h7f);
    bus(1'b1, amap[1], 32'hff, 4'hf);       // Status is read-only
    bus(1'b1, amap[5], 32'h1, 4'h0);        // Clear with lane off
    check_all();
    bus(1'b1, amap[5], 32'h1, 4'h1);        // Clear link event only
    check_all();
    for (int i = 0; i < 40; i++) begin
      if ($urandom_range(1) == 0) begin
        bus(1'b1, amap[$urandom_range(7)], $urandom,
            4'($urandom_range(15)));
      end else begin
        set_lp($urandom_range(1), 8'($urandom));
      end
      check_all();
    end
    @(posedge clk_sys);
    want <= '0;
    repeat (4) @(posedge clk_sys);
    do_reset();                             // Reset in mid-run
    check_all();
    close_out();
  end
endmodule // ppc_regs_bench
